// [common/dpg_pkg.sv]
// Notes on behaviour
// - Upper pin change raises event when enabled.
// - Lower pin change raises event when enabled.
// - Event sets status bit, mask gates interrupt.
// - Upper invert bit flips upper pin polarity.
// - Lower invert bit flips lower pin polarity.
// - Upper output enable bit drives upper pin.
// - Lower output enable bit drives lower pin.
// - Output enable zero leaves pin undriven.
// - Upper level read returns live input.
// - Upper level write sets driven level.
// - Lower level read returns live input.
// - Lower level write sets driven level.
// - Reserved fields read zero, ignore writes.
// - Bits beside interrupt enables read zero.
package dpg_pkg;
   localparam logic [7:0] PIN_CTRL_OFFSET = 8'hfc;
   localparam logic [31:0] PIN_CTRL_RESET = 32'h00000000;
   // Bits that hold state or show live levels; every other bit reads zero.
   localparam logic [31:0] PIN_CTRL_USED = 32'hb1b10000;
   localparam int UPPER_IRQ_EN_BIT = 31;
   localparam int UPPER_INVERT_BIT = 29;
   localparam int UPPER_OUT_EN_BIT = 28;
   localparam int UPPER_LEVEL_BIT = 24;
   localparam int LOWER_IRQ_EN_BIT = 23;
   localparam int LOWER_INVERT_BIT = 21;
   localparam int LOWER_OUT_EN_BIT = 20;
   localparam int LOWER_LEVEL_BIT = 16;
   localparam int UPPER_BYTE_LANE = 3;
   localparam int LOWER_BYTE_LANE = 2;
   // Edges from reset release before change detection is trusted.
   localparam logic [1:0] PRIME_EDGES = 2'h3;
endpackage

// [design/dpg_pin.sv]
`timescale 1ns/1ps
module dpg_pin (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Pin and control
   input wire logic pin_i,
   input wire logic invert_i,
   // Results
   output logic level_o,
   output logic change_o
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
      logic [1:0] prime;
      logic level;
      logic change;
   } dpg_pin_state_t;

   dpg_pin_state_t state_r;
   dpg_pin_state_t state_nxt;

   always_comb begin
      state_nxt = state_r;
      state_nxt.meta = pin_i;
      state_nxt.sync = state_r.meta;
      state_nxt.last = state_r.sync;
      if (state_r.prime != dpg_pkg::PRIME_EDGES) begin
         state_nxt.prime = 2'(state_r.prime + 2'h1);
      end
      // Change is watched on the raw level so that an invert write is not an event.
      state_nxt.change = (state_r.prime == dpg_pkg::PRIME_EDGES) &&
                         (state_r.sync != state_r.last);
      state_nxt.level = state_r.sync ^ invert_i;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign level_o = state_r.level;
   assign change_o = state_r.change;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // A pin that toggles every cycle legally gives back-to-back pulses, so only a steady
   // synchronised level demands that the pulse ends.
   chk_change_single_pulse: assert property (
         change_o && $stable(state_r.sync) |=> !change_o)
      else $error("pin change pulse lasted more than one cycle");
   chk_level_inverted: assert property (
         ##1 level_o == ($past(state_r.sync) ^ $past(invert_i)))
      else $error("pin level does not follow synchronised input and invert");
endmodule

// [design/dpg_top.sv]
`timescale 1ns/1ps
module dpg_top #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Configuration space access
   input wire logic [ADDR_W-1:0] cfg_addr_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [3:0] cfg_be_i,
   input wire logic [31:0] cfg_wdata_i,
   output logic [31:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   // Upper general pin
   input wire logic upper_general_pin_i,
   output logic upper_general_pin_o,
   output logic upper_general_pin_oe_o,
   // Lower general pin
   input wire logic lower_general_pin_i,
   output logic lower_general_pin_o,
   output logic lower_general_pin_oe_o,
   // General-purpose event towards the interrupt event and mask registers
   input wire logic gp_event_clear_i,
   input wire logic gp_event_mask_i,
   output logic gp_event_o,
   output logic gp_event_status_o,
   output logic gp_irq_o
);
   if (ADDR_W < 8) begin : g_addr_check
      $error("dpg_top: ADDR_W must be at least 8 to reach the register offset");
   end

   typedef struct packed {
      logic upper_irq_en;
      logic upper_invert;
      logic upper_out_en;
      logic upper_drive;
      logic lower_irq_en;
      logic lower_invert;
      logic lower_out_en;
      logic lower_drive;
   } dpg_ctrl_t;

   typedef struct packed {
      dpg_ctrl_t ctrl;
      logic upper_pin;
      logic upper_oe;
      logic lower_pin;
      logic lower_oe;
      logic [31:0] rdata;
      logic rvalid;
      logic event_pulse;
      logic status;
      logic irq;
   } dpg_state_t;

   dpg_state_t state_r;
   dpg_state_t state_nxt;

   logic upper_level;
   logic upper_change;
   logic lower_level;
   logic lower_change;
   logic hit;
   logic [31:0] read_word;

   dpg_pin u_upper (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(upper_general_pin_i),
      .invert_i(state_r.ctrl.upper_invert),
      .level_o(upper_level),
      .change_o(upper_change)
   );

   dpg_pin u_lower (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(lower_general_pin_i),
      .invert_i(state_r.ctrl.lower_invert),
      .level_o(lower_level),
      .change_o(lower_change)
   );

   // Widening the offset covers the upper address bits without an empty part-select.
   assign hit = (cfg_addr_i == ADDR_W'(dpg_pkg::PIN_CTRL_OFFSET));

   // Only the used bits are ever set; reserved bits stay zero on reads.
   always_comb begin
      read_word = 32'h00000000;
      read_word[dpg_pkg::UPPER_IRQ_EN_BIT] = state_r.ctrl.upper_irq_en;
      read_word[dpg_pkg::UPPER_INVERT_BIT] = state_r.ctrl.upper_invert;
      read_word[dpg_pkg::UPPER_OUT_EN_BIT] = state_r.ctrl.upper_out_en;
      read_word[dpg_pkg::UPPER_LEVEL_BIT] = upper_level;
      read_word[dpg_pkg::LOWER_IRQ_EN_BIT] = state_r.ctrl.lower_irq_en;
      read_word[dpg_pkg::LOWER_INVERT_BIT] = state_r.ctrl.lower_invert;
      read_word[dpg_pkg::LOWER_OUT_EN_BIT] = state_r.ctrl.lower_out_en;
      read_word[dpg_pkg::LOWER_LEVEL_BIT] = lower_level;
   end

   always_comb begin
      state_nxt = state_r;
      // Byte lanes gate writes; reserved bits have no storage at all.
      if (cfg_wr_i && hit && cfg_be_i[dpg_pkg::UPPER_BYTE_LANE]) begin
         state_nxt.ctrl.upper_irq_en = cfg_wdata_i[dpg_pkg::UPPER_IRQ_EN_BIT];
         state_nxt.ctrl.upper_invert = cfg_wdata_i[dpg_pkg::UPPER_INVERT_BIT];
         state_nxt.ctrl.upper_out_en = cfg_wdata_i[dpg_pkg::UPPER_OUT_EN_BIT];
         state_nxt.ctrl.upper_drive = cfg_wdata_i[dpg_pkg::UPPER_LEVEL_BIT];
      end
      if (cfg_wr_i && hit && cfg_be_i[dpg_pkg::LOWER_BYTE_LANE]) begin
         state_nxt.ctrl.lower_irq_en = cfg_wdata_i[dpg_pkg::LOWER_IRQ_EN_BIT];
         state_nxt.ctrl.lower_invert = cfg_wdata_i[dpg_pkg::LOWER_INVERT_BIT];
         state_nxt.ctrl.lower_out_en = cfg_wdata_i[dpg_pkg::LOWER_OUT_EN_BIT];
         state_nxt.ctrl.lower_drive = cfg_wdata_i[dpg_pkg::LOWER_LEVEL_BIT];
      end
      // Pins follow the new control value at the same edge the register takes it.
      state_nxt.upper_pin = state_nxt.ctrl.upper_drive ^ state_nxt.ctrl.upper_invert;
      state_nxt.upper_oe = state_nxt.ctrl.upper_out_en;
      state_nxt.lower_pin = state_nxt.ctrl.lower_drive ^ state_nxt.ctrl.lower_invert;
      state_nxt.lower_oe = state_nxt.ctrl.lower_out_en;
      // Other configuration offsets belong to other blocks, so they get no answer here.
      state_nxt.rvalid = cfg_rd_i && hit;
      state_nxt.rdata = (cfg_rd_i && hit) ? read_word : 32'h00000000;
      state_nxt.event_pulse = (upper_change && state_r.ctrl.upper_irq_en) ||
                              (lower_change && state_r.ctrl.lower_irq_en);
      // A new event beats a clear that lands in the same cycle.
      state_nxt.status = state_r.event_pulse ||
                         (state_r.status && !gp_event_clear_i);
      state_nxt.irq = state_nxt.status && gp_event_mask_i;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= '0;
         state_r.ctrl <= dpg_ctrl_t'(8'h00);
      end else begin
         state_r <= state_nxt;
      end
   end

   assign cfg_rdata_o = state_r.rdata;
   assign cfg_rvalid_o = state_r.rvalid;
   assign upper_general_pin_o = state_r.upper_pin;
   assign upper_general_pin_oe_o = state_r.upper_oe;
   assign lower_general_pin_o = state_r.lower_pin;
   assign lower_general_pin_oe_o = state_r.lower_oe;
   assign gp_event_o = state_r.event_pulse;
   assign gp_event_status_o = state_r.status;
   assign gp_irq_o = state_r.irq;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_upper_write;
      cfg_wr_i && hit && cfg_be_i[dpg_pkg::UPPER_BYTE_LANE];
   endsequence

   sequence s_lower_write;
      cfg_wr_i && hit && cfg_be_i[dpg_pkg::LOWER_BYTE_LANE];
   endsequence

   sequence s_upper_event_cause;
      upper_change && state_r.ctrl.upper_irq_en;
   endsequence

   sequence s_lower_event_cause;
      lower_change && state_r.ctrl.lower_irq_en;
   endsequence

   chk_upper_out_en: assert property (s_upper_write |=>
         upper_general_pin_oe_o == $past(cfg_wdata_i[dpg_pkg::UPPER_OUT_EN_BIT]))
      else $error("upper pin enable does not follow the written bit");

   chk_lower_out_en: assert property (s_lower_write |=>
         lower_general_pin_oe_o == $past(cfg_wdata_i[dpg_pkg::LOWER_OUT_EN_BIT]))
      else $error("lower pin enable does not follow the written bit");

   chk_oe_off_hold: assert property (
         !state_r.ctrl.upper_out_en && !(cfg_wr_i && hit && cfg_be_i[dpg_pkg::UPPER_BYTE_LANE])
         |=> !upper_general_pin_oe_o)
      else $error("upper pin driven while its enable is clear");

   chk_lower_oe_hold: assert property (
         !state_r.ctrl.lower_out_en && !(cfg_wr_i && hit && cfg_be_i[dpg_pkg::LOWER_BYTE_LANE])
         |=> !lower_general_pin_oe_o)
      else $error("lower pin driven while its enable is clear");

   chk_upper_drive: assert property (s_upper_write |=>
         upper_general_pin_o == ($past(cfg_wdata_i[dpg_pkg::UPPER_LEVEL_BIT]) ^
                                 $past(cfg_wdata_i[dpg_pkg::UPPER_INVERT_BIT])))
      else $error("upper pin level differs from written level and invert");

   chk_lower_drive: assert property (s_lower_write |=>
         lower_general_pin_o == ($past(cfg_wdata_i[dpg_pkg::LOWER_LEVEL_BIT]) ^
                                 $past(cfg_wdata_i[dpg_pkg::LOWER_INVERT_BIT])))
      else $error("lower pin level differs from written level and invert");

   chk_reserved_zero: assert property (cfg_rvalid_o |->
         (cfg_rdata_o & ~dpg_pkg::PIN_CTRL_USED) == 32'h00000000)
      else $error("reserved bits read as nonzero");

   chk_upper_live_read: assert property (cfg_rd_i && hit |=>
         cfg_rvalid_o && cfg_rdata_o[dpg_pkg::UPPER_LEVEL_BIT] == $past(upper_level))
      else $error("upper level read is not the live input");

   chk_lower_live_read: assert property (cfg_rd_i && hit |=>
         cfg_rvalid_o && cfg_rdata_o[dpg_pkg::LOWER_LEVEL_BIT] == $past(lower_level))
      else $error("lower level read is not the live input");

   chk_upper_event: assert property (
         s_upper_event_cause |=> gp_event_o ##1 gp_event_status_o)
      else $error("upper pin change did not raise the event");

   chk_lower_event: assert property (
         s_lower_event_cause |=> gp_event_o ##1 gp_event_status_o)
      else $error("lower pin change did not raise the event");

   chk_event_cause: assert property (gp_event_o |->
         $past(upper_change && state_r.ctrl.upper_irq_en) ||
         $past(lower_change && state_r.ctrl.lower_irq_en))
      else $error("event raised without an enabled pin change");

   chk_irq_mask: assert property (
         ##1 gp_irq_o == (gp_event_status_o && $past(gp_event_mask_i)))
      else $error("interrupt not gated by status and mask");

   chk_status_sticky: assert property (gp_event_status_o && !gp_event_clear_i
         |=> gp_event_status_o)
      else $error("event status dropped without a clear");

   chk_clear_loses: assert property (
         gp_event_o && gp_event_clear_i |=> gp_event_status_o)
      else $error("clear beat a simultaneous event");

   chk_no_answer_off: assert property (!(cfg_rd_i && hit) |=> !cfg_rvalid_o)
      else $error("answer given for a foreign offset");

   chk_rdata_idle: assert property (
         !cfg_rvalid_o |-> cfg_rdata_o == 32'h00000000)
      else $error("read data shown outside a read answer");

   chk_upper_ctrl_hold: assert property (
         !(cfg_wr_i && hit && cfg_be_i[dpg_pkg::UPPER_BYTE_LANE]) |=>
         $stable(upper_general_pin_o) && $stable(upper_general_pin_oe_o))
      else $error("upper pin outputs changed without a write");

   chk_lower_ctrl_hold: assert property (
         !(cfg_wr_i && hit && cfg_be_i[dpg_pkg::LOWER_BYTE_LANE]) |=>
         $stable(lower_general_pin_o) && $stable(lower_general_pin_oe_o))
      else $error("lower pin outputs changed without a write");

   chk_no_event_idle: assert property (
         !state_r.ctrl.upper_irq_en && !state_r.ctrl.lower_irq_en |=> !gp_event_o)
      else $error("event raised while both change enables are clear");
endmodule

// [sim/dual_pin_gpio_control_bench.sv]
`timescale 1ns/1ps
module dual_pin_gpio_control_bench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] cfg_addr_i = 8'h00;
   logic cfg_wr_i = 1'b0;
   logic cfg_rd_i = 1'b0;
   logic [3:0] cfg_be_i = 4'h0;
   logic [31:0] cfg_wdata_i = 32'h00000000;
   logic [31:0] cfg_rdata_o;
   logic cfg_rvalid_o;
   logic up_i = 1'b0;
   logic up_o;
   logic up_oe;
   logic lo_i = 1'b0;
   logic lo_o;
   logic lo_oe;
   logic ev_clr = 1'b0;
   logic ev_mask = 1'b0;
   logic gp_event_o;
   logic gp_event_status_o;
   logic gp_irq_o;
   int fail_count = 0;
   int n_tests = 0;
   int ev_count = 0;
   integer seed = 32'h9217;
   logic [31:0] shadow = 32'h00000000;
   logic [31:0] rdat;
   logic rv;
   logic [31:0] d;
   logic [31:0] corner [4] = '{32'hffffffff, 32'h4e4e0000, 32'h12340000, 32'h00000000};
   logic [3:0] corner_be [4] = '{4'hf, 4'hf, 4'h3, 4'hf};
   logic [3:0] be;
   logic [31:0] exp_word;
   logic vs_pending = 1'b0;
   logic vs_seen = 1'b0;

   dpg_top i_dpg_top (
      .clk_i(clk_i), .rst_i(rst_i),
      .cfg_addr_i(cfg_addr_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
      .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
      .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
      .upper_general_pin_i(up_i), .upper_general_pin_o(up_o),
      .upper_general_pin_oe_o(up_oe),
      .lower_general_pin_i(lo_i), .lower_general_pin_o(lo_o),
      .lower_general_pin_oe_o(lo_oe),
      .gp_event_clear_i(ev_clr), .gp_event_mask_i(ev_mask),
      .gp_event_o(gp_event_o), .gp_event_status_o(gp_event_status_o), .gp_irq_o(gp_irq_o)
   );

   always #20 clk_i = ~clk_i;

   // The event output is a one-cycle pulse, so each pulse is seen at exactly one edge.
   // A pulse met by a held clear must still leave the status set one edge later.
   always @(posedge clk_i) begin
      if (vs_pending) begin
         check(gp_event_status_o, 1'b1);
      end
      vs_pending <= (gp_event_o === 1'b1) && (ev_clr === 1'b1);
      if (gp_event_o === 1'b1) begin
         ev_count++;
         if (ev_clr === 1'b1) begin
            vs_seen <= 1'b1;
         end
      end
   end

   function automatic logic [31:0] upd(logic [31:0] c, logic [3:0] b, logic [31:0] w);
      if (b[3]) begin
         c[31:24] = w[31:24];
      end
      if (b[2]) begin
         c[23:16] = w[23:16];
      end
      return c & dpg_pkg::PIN_CTRL_USED;
   endfunction

   function automatic logic [31:0] exp_read(logic [31:0] c, logic u, logic l);
      logic [31:0] e;
      e = c & 32'hb0b00000;
      e[24] = u ^ c[29];
      e[16] = l ^ c[21];
      return e;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] w);
      @(posedge clk_i);
      cfg_wr_i <= 1'b1;
      cfg_addr_i <= a;
      cfg_be_i <= b;
      cfg_wdata_i <= w;
      @(posedge clk_i);
      cfg_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic v, output logic [31:0] r);
      @(posedge clk_i);
      cfg_rd_i <= 1'b1;
      cfg_addr_i <= a;
      @(posedge clk_i);
      cfg_rd_i <= 1'b0;
      #1;
      v = cfg_rvalid_o;
      r = cfg_rdata_o;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      #(40 * 20000);
      fail_count++;
      complete_run();
   end

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      settle(4);
      rd(8'hfc, rv, rdat);
      check(rv, 1'b1);
      check(rdat, 32'h00000000);
      check({up_oe, lo_oe, gp_event_status_o}, 3'h0);
      $display("test reset done");
      for (int i = 0; i < 44; i++) begin
         d = (i < 4) ? corner[i] : $random(seed);
         be = (i < 4) ? corner_be[i] : 4'($random(seed));
         @(posedge clk_i);
         up_i <= 1'($random(seed));
         lo_i <= 1'($random(seed));
         wr(8'hf8, 4'hf, ~d);
         wr(8'hfc, be, d);
         shadow = upd(shadow, be, d);
         settle(4);
         rd(8'hfc, rv, rdat);
         check(rv, 1'b1);
         exp_word = exp_read(shadow, up_i, lo_i);
         check(rdat, exp_word);
         check(up_oe, shadow[28]);
         check(lo_oe, shadow[20]);
         check(up_o, shadow[24] ^ shadow[29]);
         check(lo_o, shadow[16] ^ shadow[21]);
      end
      rd(8'hf8, rv, rdat);
      check(rv, 1'b0);
      check(rdat, 32'h0);
      $display("test register done");
      @(posedge clk_i);
      up_i <= 1'b0;
      lo_i <= 1'b0;
      ev_mask <= 1'b1;
      wr(8'hfc, 4'hf, 32'h80800000);
      settle(6);
      @(posedge clk_i);
      ev_clr <= 1'b1;
      @(posedge clk_i);
      ev_clr <= 1'b0;
      settle(2);
      ev_count = 0;
      check(gp_event_status_o, 1'b0);
      up_i <= 1'b1;
      settle(6);
      check(ev_count, 1);
      check({gp_event_status_o, gp_irq_o}, 2'h3);
      ev_mask <= 1'b0;
      settle(2);
      check({gp_event_status_o, gp_irq_o}, 2'h2);
      ev_clr <= 1'b1;
      @(posedge clk_i);
      ev_clr <= 1'b0;
      settle(2);
      check(gp_event_status_o, 1'b0);
      lo_i <= 1'b1;
      settle(6);
      check(ev_count, 2);
      check({gp_event_status_o, gp_irq_o}, 2'h2);
      // The clear stays high across a pin change, so event and clear meet in one cycle.
      ev_clr <= 1'b1;
      up_i <= 1'b0;
      settle(6);
      check(ev_count, 3);
      check(gp_event_status_o, 1'b0);
      ev_clr <= 1'b0;
      check(vs_seen, 1'b1);
      wr(8'hfc, 4'hf, 32'ha0a00000);
      settle(6);
      check(ev_count, 3);
      wr(8'hfc, 4'hf, 32'h00000000);
      up_i <= 1'b1;
      lo_i <= 1'b0;
      settle(6);
      check(ev_count, 3);
      $display("test events done");
      @(posedge clk_i);
      rst_i <= 1'b1;
      up_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      settle(4);
      rd(8'hfc, rv, rdat);
      check(rv, 1'b1);
      check(rdat, dpg_pkg::PIN_CTRL_RESET);
      check({up_oe, lo_oe, gp_event_status_o, gp_irq_o}, 4'h0);
      check(ev_count, 3);
      $display("test mid-run reset done");
      complete_run();
   end
endmodule
